//--- rtl/fpc_device.sv
// Implementation choice: the AHB-Lite interface to the registers.
`include "fpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fpc_device #(
    parameter int PROG_CYCLES = `FPC_PROG_CYCLES,
    parameter int PAGES       = `FPC_USER_PAGES,
    parameter int PAGE_BYTES  = `FPC_PAGE_BYTES
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    fpc_if.dev        bus
);

    localparam int UBYTES = PAGES * PAGE_BYTES;

    fpc_pkg::fpc_dev_state_type s_r;
    fpc_pkg::fpc_dev_state_type s_nxt;

    logic [7:0] user_mem [UBYTES];
    logic [7:0] extra_row_space_mem [PAGE_BYTES];
    logic [7:0] latch_mem [PAGE_BYTES];
    logic       done;
    logic       ctrl_wr;
    logic       load_en;

    function automatic logic [7:0] user_rd(input logic [15:0] a);
        user_rd = user_mem[a[14:0]];
    endfunction

    function automatic logic ctrl_hit(input logic [7:0] a);
        ctrl_hit = (a == `FPC_CTRL_SFR_ADDR);
    endfunction

    function automatic fpc_pkg::fpc_space_type space_of(input logic [7:0] v);
        space_of = fpc_pkg::fpc_space_type'(v[`FPC_SEL_HI:`FPC_SEL_LO]);
    endfunction

    function automatic logic [6:0] byte_idx(input logic [15:0] a);
        byte_idx = a[6:0];
    endfunction

    function automatic logic [7:0] page_idx(input logic [15:0] a);
        page_idx = a[14:7];
    endfunction

    assign done    = s_r.ctrl[`FPC_BUSY_BIT] && (s_r.cnt == 32'd1);
    assign load_en = bus.xd_wr && s_r.ctrl[`FPC_MAP_BIT] && !s_r.ctrl[`FPC_BUSY_BIT];
    assign ctrl_wr = bus.sfr_wr && ctrl_hit(bus.sfr_addr) && !s_r.ctrl[`FPC_BUSY_BIT];

    always_comb begin
        logic [3:0]          lf;
        fpc_pkg::fpc_space_type sel;
        lf = bus.sfr_wdata[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO];
        sel = space_of(s_r.ctrl);
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;

        if (ctrl_wr) begin
            s_nxt.ctrl[7:1] = bus.sfr_wdata[7:1];
            s_nxt.armed = (lf == `FPC_LAUNCH_ARM);
            if (lf == `FPC_LAUNCH_GO && s_r.armed
                    && space_of(bus.sfr_wdata) != fpc_pkg::FPC_SEL_RESVD) begin
                s_nxt.prog_sel = space_of(bus.sfr_wdata);
                s_nxt.ctrl[`FPC_BUSY_BIT] = 1'b1;
                s_nxt.cnt = PROG_CYCLES[31:0];
            end
        end

        if (s_r.ctrl[`FPC_BUSY_BIT]) begin
            s_nxt.cnt = s_r.cnt - 32'd1;
            if (done) begin
                s_nxt.ctrl[`FPC_BUSY_BIT] = 1'b0;
                s_nxt.loaded = '0;
            end
        end

        if (done && s_r.prog_sel == fpc_pkg::FPC_SEL_SECUR && s_r.loaded[0]) begin
            s_nxt.secur = {latch_mem[0][7:4], s_r.secur[3:0]};
        end

        if (load_en) begin
            s_nxt.loaded[byte_idx(bus.xd_addr)] = 1'b1;
            s_nxt.page = page_idx(bus.xd_addr);
        end

        s_nxt.idle = s_nxt.ctrl[`FPC_BUSY_BIT];

        if (bus.sfr_rd) begin
            s_nxt.rvalid = 1'b1;
            if (ctrl_hit(bus.sfr_addr)) begin
                s_nxt.sfr_rdata = s_r.ctrl;
            end else begin
                s_nxt.sfr_rdata = 8'h00;
            end
        end

        if (bus.code_rd) begin
            s_nxt.rvalid = 1'b1;
            unique case (sel)
                fpc_pkg::FPC_SEL_USER: begin
                    s_nxt.code_rdata = user_rd(bus.code_addr);
                end
                fpc_pkg::FPC_SEL_EXTRA_ROW_SPACE: begin
                    if (bus.code_addr >= `FPC_EXTRA_ROW_SPACE_BASE) begin
                        s_nxt.code_rdata = extra_row_space_mem[byte_idx(bus.code_addr)];
                    end else begin
                        s_nxt.code_rdata = user_rd(bus.code_addr);
                    end
                end
                fpc_pkg::FPC_SEL_SECUR: begin
                    if (bus.code_addr == 16'h0000) begin
                        s_nxt.code_rdata = s_r.secur;
                    end else begin
                        s_nxt.code_rdata = user_rd(bus.code_addr);
                    end
                end
                fpc_pkg::FPC_SEL_RESVD: begin
                    s_nxt.code_rdata = user_rd(bus.code_addr);
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge hclk) begin
        if (ce && load_en) begin
            latch_mem[byte_idx(bus.xd_addr)] <= bus.xd_wdata;
        end
    end

    always_ff @(posedge hclk) begin
        if (ce && done) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (s_r.loaded[i]) begin
                    unique case (s_r.prog_sel)
                        fpc_pkg::FPC_SEL_USER: begin
                            user_mem[{s_r.page, i[6:0]}] <= latch_mem[i];
                        end
                        fpc_pkg::FPC_SEL_EXTRA_ROW_SPACE: begin
                            extra_row_space_mem[i] <= latch_mem[i];
                        end
                        fpc_pkg::FPC_SEL_SECUR: begin
                        end
                        fpc_pkg::FPC_SEL_RESVD: begin
                        end
                    endcase
                end
            end
        end
    end

    assign bus.sfr_rdata  = s_r.sfr_rdata;
    assign bus.code_rdata = s_r.code_rdata;
    assign bus.rvalid     = s_r.rvalid;
    assign bus.cpu_idle   = s_r.idle;

endmodule
`default_nettype wire

//--- rtl/fpc_defines.svh
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

`define FPC_CTRL_SFR_ADDR   8'hD1
`define FPC_CTRL_RESET      8'h00
`define FPC_LAUNCH_HI       7
`define FPC_LAUNCH_LO       4
`define FPC_MAP_BIT         3
`define FPC_SEL_HI          2
`define FPC_SEL_LO          1
`define FPC_BUSY_BIT        0
`define FPC_LAUNCH_ARM      4'h5
`define FPC_LAUNCH_GO       4'hA
`define FPC_EXTRA_ROW_SPACE_BASE       16'hFF80
`define FPC_PAGE_BYTES      128
`define FPC_USER_PAGES      256
`define FPC_PROG_TIME_MS    10
`define FPC_CLK_KHZ         200000
`define FPC_PROG_CYCLES     (`FPC_PROG_TIME_MS * `FPC_CLK_KHZ)

`define FPC_REG_CMD         8'h00
`define FPC_REG_ADDR        8'h04
`define FPC_REG_WDATA       8'h08
`define FPC_REG_STATUS      8'h0C
`define FPC_ST_BUSY_BIT     8
`define FPC_ST_PEND_BIT     9

`endif

//--- rtl/fpc_pkg.sv
package fpc_pkg;

    typedef enum logic [1:0] {
        FPC_SEL_USER   = 2'b00,
        FPC_SEL_EXTRA_ROW_SPACE   = 2'b01,
        FPC_SEL_SECUR  = 2'b10,
        FPC_SEL_RESVD  = 2'b11
    } fpc_space_type;

    typedef enum logic [1:0] {
        FPC_OP_SFR_WR  = 2'b00,
        FPC_OP_XD_WR   = 2'b01,
        FPC_OP_CODE_RD = 2'b10,
        FPC_OP_SFR_RD  = 2'b11
    } fpc_op_type;

    typedef enum logic [1:0] {
        FPC_H_IDLE  = 2'b00,
        FPC_H_ISSUE = 2'b01,
        FPC_H_WAIT  = 2'b10
    } fpc_hstate_type;

    typedef struct packed {
        logic [7:0]    ctrl;
        logic          armed;
        fpc_space_type prog_sel;
        logic [31:0]   cnt;
        logic [7:0]    page;
        logic [127:0]  loaded;
        logic [7:0]    code_rdata;
        logic [7:0]    sfr_rdata;
        logic          rvalid;
        logic          idle;
        logic [7:0]    secur;
    } fpc_dev_state_type;

    typedef struct packed {
        fpc_hstate_type st;
        fpc_op_type     op;
        logic [15:0]    addr;
        logic [7:0]     wdata;
        logic [7:0]     rdata;
        logic           d_wr;
        logic [7:0]     d_off;
        logic           d_act;
        logic [31:0]    hrdata;
        logic           sfr_wr;
        logic           sfr_rd;
        logic           xd_wr;
        logic           code_rd;
        logic           ready;
        logic           resp;
    } fpc_host_state_type;

endpackage

//--- rtl/fpc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpc_if;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        xd_wr;
    logic [15:0] xd_addr;
    logic [7:0]  xd_wdata;
    logic        code_rd;
    logic [15:0] code_addr;
    logic [7:0]  code_rdata;
    logic        rvalid;
    logic        cpu_idle;

    modport dev (
        input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xd_wr, xd_addr, xd_wdata,
        input  code_rd, code_addr,
        output sfr_rdata, code_rdata, rvalid, cpu_idle
    );
    modport host (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xd_wr, xd_addr, xd_wdata,
        output code_rd, code_addr,
        input  sfr_rdata, code_rdata, rvalid, cpu_idle
    );
endinterface
`default_nettype wire

//--- rtl/fpc_host.sv
`include "fpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fpc_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    fpc_if.host              bus
);

    fpc_pkg::fpc_host_state_type s_r;
    fpc_pkg::fpc_host_state_type s_nxt;

    always_comb begin
        logic take;
        take = hsel && hready && htrans[1];
        s_nxt = s_r;
        s_nxt.sfr_wr = 1'b0;
        s_nxt.sfr_rd = 1'b0;
        s_nxt.xd_wr = 1'b0;
        s_nxt.code_rd = 1'b0;
        s_nxt.d_act = take;
        s_nxt.d_wr = hwrite;
        s_nxt.d_off = haddr[7:0];
        s_nxt.hrdata = 32'h0000_0000;
        s_nxt.ready = 1'b1;
        s_nxt.resp = 1'b0;
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                `FPC_REG_ADDR: s_nxt.hrdata = {16'h0000, s_r.addr};
                `FPC_REG_WDATA: s_nxt.hrdata = {24'h000000, s_r.wdata};
                `FPC_REG_STATUS: s_nxt.hrdata = {22'h0,
                    s_r.st != fpc_pkg::FPC_H_IDLE, bus.cpu_idle, s_r.rdata};
                default: s_nxt.hrdata = 32'h0000_0000;
            endcase
        end
        if (s_r.d_act && s_r.d_wr) begin
            unique case (s_r.d_off)
                `FPC_REG_ADDR: s_nxt.addr = hwdata[15:0];
                `FPC_REG_WDATA: s_nxt.wdata = hwdata[7:0];
                `FPC_REG_CMD: begin
                    if (s_r.st == fpc_pkg::FPC_H_IDLE && !bus.cpu_idle) begin
                        s_nxt.op = fpc_pkg::fpc_op_type'(hwdata[1:0]);
                        s_nxt.st = fpc_pkg::FPC_H_ISSUE;
                    end
                end
                default: begin
                end
            endcase
        end
        unique case (s_r.st)
            fpc_pkg::FPC_H_IDLE: begin
            end
            fpc_pkg::FPC_H_ISSUE: begin
                s_nxt.sfr_wr = (s_r.op == fpc_pkg::FPC_OP_SFR_WR);
                s_nxt.sfr_rd = (s_r.op == fpc_pkg::FPC_OP_SFR_RD);
                s_nxt.xd_wr = (s_r.op == fpc_pkg::FPC_OP_XD_WR);
                s_nxt.code_rd = (s_r.op == fpc_pkg::FPC_OP_CODE_RD);
                s_nxt.st = fpc_pkg::FPC_H_WAIT;
            end
            fpc_pkg::FPC_H_WAIT: begin
                if (s_r.op == fpc_pkg::FPC_OP_CODE_RD || s_r.op == fpc_pkg::FPC_OP_SFR_RD) begin
                    if (bus.rvalid) begin
                        s_nxt.rdata = (s_r.op == fpc_pkg::FPC_OP_CODE_RD)
                            ? bus.code_rdata : bus.sfr_rdata;
                        s_nxt.st = fpc_pkg::FPC_H_IDLE;
                    end
                end else begin
                    s_nxt.st = fpc_pkg::FPC_H_IDLE;
                end
            end
            default: s_nxt.st = fpc_pkg::FPC_H_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign hrdata        = s_r.hrdata;
    assign hreadyout     = s_r.ready;
    assign hresp         = s_r.resp;
    assign bus.sfr_wr    = s_r.sfr_wr;
    assign bus.sfr_rd    = s_r.sfr_rd;
    assign bus.sfr_addr  = s_r.addr[7:0];
    assign bus.sfr_wdata = s_r.wdata;
    assign bus.xd_wr     = s_r.xd_wr;
    assign bus.xd_addr   = s_r.addr;
    assign bus.xd_wdata  = s_r.wdata;
    assign bus.code_rd   = s_r.code_rd;
    assign bus.code_addr = s_r.addr;

endmodule
`default_nettype wire

//--- dv/fpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_properties #(
    parameter int PROG_CYCLES = 2000000
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       code_rd,
    input wire logic       rvalid,
    input wire logic       cpu_idle
);
    logic        ctrl_wr;
    logic        armed_r;
    logic        rd_ctrl_r;
    logic [6:0]  shadow_r;
    logic [31:0] busy_cnt_r;

    assign ctrl_wr = sfr_wr && sfr_addr == 8'hD1 && !cpu_idle;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_r <= 1'b0;
            rd_ctrl_r <= 1'b0;
            shadow_r <= 7'h00;
            busy_cnt_r <= 32'h0;
        end else begin
            if (ctrl_wr) begin
                armed_r <= sfr_wdata[7:4] == 4'h5;
                shadow_r <= sfr_wdata[7:1];
            end
            rd_ctrl_r <= sfr_rd && sfr_addr == 8'hD1;
            busy_cnt_r <= cpu_idle ? busy_cnt_r + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_read_answer: assert property (
        (sfr_rd || code_rd) |=> rvalid) else $error("Read not answered next cycle.");
    chk_answer_cause: assert property (
        rvalid |-> $past(sfr_rd || code_rd)) else $error("Answer without a read.");
    chk_launch_starts: assert property (
        ctrl_wr && sfr_wdata[7:4] == 4'hA && armed_r && sfr_wdata[2:1] != 2'b11 |=> cpu_idle)
        else $error("Launch did not start.");
    chk_unpaired_go: assert property (
        ctrl_wr && sfr_wdata[7:4] == 4'hA && !armed_r |=> !cpu_idle)
        else $error("Unpaired launch started.");
    chk_reserved_mode: assert property (
        ctrl_wr && sfr_wdata[2:1] == 2'b11 |=> !cpu_idle) else $error("Reserved mode started.");
    chk_busy_length: assert property (
        $fell(cpu_idle) |-> busy_cnt_r == PROG_CYCLES) else $error("Busy length wrong.");
    chk_busy_bound: assert property (
        cpu_idle |-> busy_cnt_r < PROG_CYCLES) else $error("Busy too long.");
    chk_idle_cause: assert property (
        $rose(cpu_idle) |-> $past(ctrl_wr)) else $error("Idle without launch.");
    chk_ctrl_readback: assert property (
        rvalid && rd_ctrl_r |-> sfr_rdata == {shadow_r, 1'b0}) else $error("Control read wrong.");

    cover property ($rose(cpu_idle));
    cover property (rvalid && rd_ctrl_r);
    cover property (code_rd);
endmodule
`default_nettype wire

//--- dv/flash_program_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_program_control_bench;
    localparam int PC = 40;
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] s;
    int          fail_count;
    int          compares;

    fpc_if bus ();
    fpc_device #(.PROG_CYCLES(PC)) i_fpc_device (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .bus(bus));
    fpc_host i_fpc_host (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .bus(bus));
    fpc_properties #(.PROG_CYCLES(PC)) i_fpc_properties (
        .hclk(hclk), .hresetn(hresetn), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd),
        .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata),
        .code_rd(bus.code_rd), .rvalid(bus.rvalid), .cpu_idle(bus.cpu_idle));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        s = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task poll(input int bit_no, input int lim);
        int n;
        n = 0;
        do begin
            ahb(1'b0, 8'h0C, 32'h0);
            n++;
        end while ((s[bit_no] !== 1'b0 || n < 3) && n < lim);
        if (s[bit_no] !== 1'b0) begin
            fail_count++;
            final_report();
        end
    endtask

    task cmd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
        ahb(1'b1, 8'h04, {16'h0, a});
        ahb(1'b1, 8'h08, {24'h0, d});
        ahb(1'b1, 8'h00, {30'h0, op});
        poll(9, 50);
    endtask

    task wr(input logic [7:0] v);
        cmd(2'h0, 16'h00D1, v);
    endtask

    task launch(input logic [3:0] m, input logic go);
        wr({4'h5, m});
        wr({4'hA, m});
        ahb(1'b0, 8'h0C, 32'h0);
        check(s[8], go);
        poll(8, 100);
    endtask

    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmd(2'h3, 16'h00D1, 8'h00);
        check(s[7:0], 8'h00);
        ahb(1'b0, 8'h10, 32'h0);
        check(s, 32'h0);
        wr(8'h01);
        cmd(2'h3, 16'h00D1, 8'h00);
        check(s[7:0], 8'h00);
        wr(8'h0C);
        cmd(2'h3, 16'h00D1, 8'h00);
        check(s[7:0], 8'h0C);
        cmd(2'h1, 16'h0000, 8'hA5);
        launch(4'h4, 1'b1);
        wr(8'h04);
        cmd(2'h2, 16'h0000, 8'h00);
        check(s[7:0], 8'hA0);
        wr(8'h08);
        cmd(2'h1, 16'h0101, 8'h11);
        cmd(2'h1, 16'h0282, 8'h22);
        launch(4'h0, 1'b1);
        wr(8'h00);
        cmd(2'h2, 16'h0281, 8'h00);
        check(s[7:0], 8'h11);
        cmd(2'h2, 16'h8282, 8'h00);
        check(s[7:0], 8'h22);
        wr(8'h08);
        cmd(2'h1, 16'h0282, 8'h5D);
        launch(4'h0, 1'b1);
        wr(8'h00);
        cmd(2'h2, 16'h0282, 8'h00);
        check(s[7:0], 8'h5D);
        cmd(2'h2, 16'h0281, 8'h00);
        check(s[7:0], 8'h11);
        wr(8'h08);
        cmd(2'h1, 16'hFF85, 8'h77);
        launch(4'h2, 1'b1);
        wr(8'h02);
        cmd(2'h2, 16'hFF85, 8'h00);
        check(s[7:0], 8'h77);
        cmd(2'h2, 16'h0282, 8'h00);
        check(s[7:0], 8'h5D);
        wr(8'h50);
        wr(8'h00);
        wr(8'hA0);
        ahb(1'b0, 8'h0C, 32'h0);
        check(s[8], 1'b0);
        launch(4'h6, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
